// file: udi_map.svh
/*
 Register indices, field positions, reset values and timing counts of the
 USB interrupt and isochronous status block.
 Assumes inclusion by bare name; byte address is four times the index.
*/
`ifndef UDI_MAP_SVH
`define UDI_MAP_SVH
`define UDI_IDX_OUT_DATA  16'hc760
`define UDI_IDX_IN_DATA   16'hc768
`define UDI_IDX_CNT_HIGH  16'hc770
`define UDI_IDX_CNT_LOW   16'hc771
`define UDI_IDX_ISO_ERR   16'hc7a0
`define UDI_IDX_ZERO_LEN  16'hc7a2
`define UDI_IDX_IVEC      16'hc7a8
`define UDI_IDX_IN_IRQ    16'hc7a9
`define UDI_IDX_OUT_IRQ   16'hc7aa
`define UDI_IDX_BUS_IRQ   16'hc7ab
`define UDI_IDX_IN_IEN    16'hc7ac
`define UDI_IDX_OUT_IEN   16'hc7ad
`define UDI_IDX_BUS_IEN   16'hc7ae
`define UDI_IDX_BULK_LO   16'hc440
`define UDI_IDX_BULK_HI   16'hc73f
`define UDI_BIT_SOF       1
`define UDI_VEC_EP_BASE   7'h18
`define UDI_ISO_OUT_BASE  9'h0c0
`define UDI_ISO_IN_BASE   9'h1c0
`define UDI_ISO_MAX       7'h40
`define UDI_RST_IEN       6'h00
`define UDI_RST_BUS_IEN   5'h00
`define UDI_PULSE_CYC     2
`define UDI_RESP_OKAY     2'h0
`define UDI_RESP_DECERR   2'h3
`endif

// file: udi_pkg.sv
/*
 Types of the USB interrupt and isochronous status block.
 Assumes udi_map.svh for all numeric constants.
*/
package udi_pkg;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        arready;
      logic        aw_h;
      logic [15:0] aw_idx;
      logic        w_h;
      logic [7:0]  wd;
      logic        ws;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [7:0]  rdata;
      logic [1:0]  rresp;
      logic [5:0]  in_irq;
      logic [5:0]  out_irq;
      logic [4:0]  bus_irq;
      logic [5:0]  in_ien;
      logic [5:0]  out_ien;
      logic [4:0]  bus_ien;
      logic [6:0]  ivec;
      logic        irq;
      logic [1:0]  pcnt;
      logic        clr_seen;
      logic        any_prev;
      logic [6:0]  rx_cnt;
      logic        crc_pend;
      logic        zero_pend;
      logic [15:0] out_cnt;
      logic        crc_err;
      logic        zero_len;
      logic [5:0]  rd_ptr;
      logic [6:0]  in_wr;
      logic [6:0]  tx_len;
      logic [5:0]  tx_ptr;
      logic [7:0]  tx_byte;
   } udi_state_s;
endpackage : udi_pkg

// file: udi_ctrl.sv
/*
 USB controller interrupt aggregation, vector, isochronous endpoint 8
 status and data ports, and bulk buffer windows, over AXI4-Lite.
 Assumes the protocol engine on ref_clk drives one-cycle event pulses.
*/
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "udi_map.svh"

// Function
// - Twelve bulk and five bus events merge onto one request line
// - Clearing a flag re-pulses for the next pending request
// - Simultaneous sources are prioritised; vector register shows active
// - Codes: bus events 0x00..0x10, endpoint n IN 0x18+8n, OUT +4
// - CRC error status refreshed at each start of frame
// - Packet bytes stay readable despite a CRC error
// - Zero-length status set after zero-byte packet last frame
// - Bulk IN flag set on acknowledged IN packet, write one clears
// - Bulk OUT flag set on error-free OUT packet, write one clears
// - Bus-event flags: reset 4, suspend 3, token 2, frame 1, data 0
// - Writing one clears a bus-event flag, zero leaves it
// - Bulk IN enable bits 5:0 enable IN endpoint interrupts
// - Bulk OUT enable bits 5:0 enable OUT endpoint interrupts
// - Received iso byte count read as high and low bytes
// - Each iso OUT data read returns next received byte
// - Each iso IN data write appends one byte, up to 64 per frame
// - Bulk IN buffers of 32 bytes in fixed 64-index windows, endpoint 0 top
// - Bulk OUT buffers of 32 bytes in 64-index windows interleaved with IN
// - Each request is a short high pulse
// - Bus-event enables use the same bit positions as the flags
module udi_ctrl #(
   parameter int PULSE_CYC = `UDI_PULSE_CYC
) (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic [17:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [17:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [5:0]  ev_in_ack,
   input  wire logic [5:0]  ev_out_ok,
   input  wire logic [4:0]  ev_bus,
   input  wire logic        iso_rx_valid,
   input  wire logic [7:0]  iso_rx_byte,
   input  wire logic        iso_rx_end,
   input  wire logic        iso_rx_crc_err,
   input  wire logic        iso_tx_rd,
   output logic [7:0]       iso_tx_byte,
   output logic [6:0]       iso_tx_len,
   output logic             irq_o
);
   if (PULSE_CYC < 1 || PULSE_CYC > 3) begin : g_chk
      $error("PULSE_CYC must be 1 to 3");
   end

   udi_pkg::udi_state_s q;
   udi_pkg::udi_state_s d;
   logic [7:0]  mem [512];
   logic [16:0] pend;
   logic        any;
   logic        trig;
   logic        sw_we;
   logic [8:0]  sw_wa;
   logic        rx_we;
   logic [8:0]  rx_wa;
   logic [8:0]  rd_a;
   logic [8:0]  tx_a;
   logic [15:0] ar_idx;
   logic [9:0]  bw;
   logic [9:0]  br;
   logic [5:0]  clr_in;
   logic [5:0]  clr_out;
   logic [4:0]  clr_bus;

   // Window n*128 from the low end holds OUT then IN of endpoint 5-n
   function automatic logic [9:0] bulk_map(input logic [15:0] idx);
      logic [15:0] rel;
      rel = idx - `UDI_IDX_BULK_LO;
      bulk_map = 10'h000;
      if (idx >= `UDI_IDX_BULK_LO && idx <= `UDI_IDX_BULK_HI) begin
         bulk_map = {1'b1, rel[6], 3'd5 - rel[9:7], rel[4:0]};
      end
   endfunction : bulk_map

   // Source order equals vector order: bus events, then IN/OUT pairs
   assign pend[4:0] = q.bus_irq & q.bus_ien;
   for (genvar i = 0; i < 6; i++) begin : g_ep
      assign pend[5+2*i] = q.in_irq[i] & q.in_ien[i];
      assign pend[6+2*i] = q.out_irq[i] & q.out_ien[i];
   end
   assign any    = |pend;
   // New pending while idle, or anything left after a clear
   assign trig   = (any && !q.any_prev) || (q.clr_seen && any);
   assign ar_idx = s_axi_araddr[17:2];
   assign bw     = bulk_map(q.aw_idx);
   assign br     = bulk_map(ar_idx);

   always_comb begin
      d       = q;
      sw_we   = 1'b0;
      sw_wa   = bw[8:0];
      rx_we   = 1'b0;
      rx_wa   = `UDI_ISO_OUT_BASE + {3'h0, q.rx_cnt[5:0]};
      rd_a    = br[8:0];
      tx_a    = `UDI_ISO_IN_BASE + {3'h0, q.tx_ptr};
      clr_in  = 6'h00;
      clr_out = 6'h00;
      clr_bus = 5'h00;
      if (s_axi_awvalid && q.awready) begin
         d.aw_h   = 1'b1;
         d.aw_idx = s_axi_awaddr[17:2];
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_h = 1'b1;
         d.wd  = s_axi_wdata[7:0];
         d.ws  = s_axi_wstrb[0];
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_h && q.w_h && !q.bvalid) begin
         d.aw_h   = 1'b0;
         d.w_h    = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = `UDI_RESP_OKAY;
         case (q.aw_idx)
            `UDI_IDX_IN_IRQ:  clr_in = q.ws ? q.wd[5:0] : 6'h00;
            `UDI_IDX_OUT_IRQ: clr_out = q.ws ? q.wd[5:0] : 6'h00;
            `UDI_IDX_BUS_IRQ: clr_bus = q.ws ? q.wd[4:0] : 5'h00;
            `UDI_IDX_IN_IEN: begin
               if (q.ws) d.in_ien = q.wd[5:0];
            end
            `UDI_IDX_OUT_IEN: begin
               if (q.ws) d.out_ien = q.wd[5:0];
            end
            `UDI_IDX_BUS_IEN: begin
               if (q.ws) d.bus_ien = q.wd[4:0];
            end
            `UDI_IDX_IN_DATA: begin
               if (q.ws && q.in_wr < `UDI_ISO_MAX) begin
                  sw_we   = 1'b1;
                  sw_wa   = `UDI_ISO_IN_BASE + {3'h0, q.in_wr[5:0]};
                  d.in_wr = q.in_wr + 7'h01;
               end
            end
            `UDI_IDX_OUT_DATA, `UDI_IDX_CNT_HIGH, `UDI_IDX_CNT_LOW,
            `UDI_IDX_ISO_ERR, `UDI_IDX_ZERO_LEN, `UDI_IDX_IVEC: ;
            default: begin
               if (bw[9]) begin
                  sw_we = q.ws;
               end else begin
                  d.bresp = `UDI_RESP_DECERR;
               end
            end
         endcase
      end
      d.awready = !d.aw_h && !d.bvalid;
      d.wready  = !d.w_h && !d.bvalid;

      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rresp  = `UDI_RESP_OKAY;
         d.rdata  = 8'h00;
         case (ar_idx)
            `UDI_IDX_OUT_DATA: begin
               rd_a     = `UDI_ISO_OUT_BASE + {3'h0, q.rd_ptr};
               d.rdata  = mem[rd_a];
               d.rd_ptr = q.rd_ptr + 6'h01;
            end
            `UDI_IDX_IN_DATA:  d.rdata = 8'h00;
            `UDI_IDX_CNT_HIGH: d.rdata = q.out_cnt[15:8];
            `UDI_IDX_CNT_LOW:  d.rdata = q.out_cnt[7:0];
            `UDI_IDX_ISO_ERR:  d.rdata = {7'h00, q.crc_err};
            `UDI_IDX_ZERO_LEN: d.rdata = {7'h00, q.zero_len};
            `UDI_IDX_IVEC:     d.rdata = {1'b0, q.ivec};
            `UDI_IDX_IN_IRQ:   d.rdata = {2'h0, q.in_irq};
            `UDI_IDX_OUT_IRQ:  d.rdata = {2'h0, q.out_irq};
            `UDI_IDX_BUS_IRQ:  d.rdata = {3'h0, q.bus_irq};
            `UDI_IDX_IN_IEN:   d.rdata = {2'h0, q.in_ien};
            `UDI_IDX_OUT_IEN:  d.rdata = {2'h0, q.out_ien};
            `UDI_IDX_BUS_IEN:  d.rdata = {3'h0, q.bus_ien};
            default: begin
               if (br[9]) begin
                  d.rdata = mem[rd_a];
               end else begin
                  d.rresp = `UDI_RESP_DECERR;
               end
            end
         endcase
      end
      d.arready = !d.rvalid;

      // Set wins over a clear in the same cycle
      d.in_irq   = (q.in_irq & ~clr_in) | ev_in_ack;
      d.out_irq  = (q.out_irq & ~clr_out) | ev_out_ok;
      d.bus_irq  = (q.bus_irq & ~clr_bus) | ev_bus;
      d.clr_seen = |{clr_in, clr_out, clr_bus};
      d.any_prev = any;

      d.ivec = q.ivec;
      for (int i = 16; i >= 0; i--) begin
         if (pend[i]) begin
            if (i < 5) begin
               d.ivec = 7'(i * 4);
            end else begin
               d.ivec = `UDI_VEC_EP_BASE + 7'((i - 5) * 4);
            end
         end
      end
      if (trig) begin
         d.pcnt = 2'(PULSE_CYC);
      end else if (q.pcnt != 2'h0) begin
         d.pcnt = q.pcnt - 2'h1;
      end
      d.irq = d.pcnt != 2'h0;

      if (iso_rx_valid && !q.rx_cnt[6]) begin
         rx_we    = 1'b1;
         d.rx_cnt = q.rx_cnt + 7'h01;
      end
      if (iso_rx_end) begin
         d.crc_pend = q.crc_pend | iso_rx_crc_err;
         if (q.rx_cnt == 7'h00) d.zero_pend = 1'b1;
      end
      if (iso_tx_rd) begin
         d.tx_byte = mem[tx_a];
         d.tx_ptr  = q.tx_ptr + 6'h01;
      end
      // Frame boundary: publish last frame, restart both read and both write pointers
      if (ev_bus[`UDI_BIT_SOF]) begin
         d.out_cnt   = {9'h000, q.rx_cnt};
         d.crc_err   = q.crc_pend;
         d.zero_len  = q.zero_pend;
         d.crc_pend  = 1'b0;
         d.zero_pend = 1'b0;
         d.rx_cnt    = 7'h00;
         d.rd_ptr    = 6'h00;
         d.tx_len    = q.in_wr;
         d.in_wr     = 7'h00;
         d.tx_ptr    = 6'h00;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         q         <= '0;
         q.in_ien  <= `UDI_RST_IEN;
         q.out_ien <= `UDI_RST_IEN;
         q.bus_ien <= `UDI_RST_BUS_IEN;
      end else begin
         q <= d;
      end
   end

   // Buffer memory has no reset; software and engine write separate areas
   always_ff @(posedge ref_clk) begin
      if (sw_we) begin
         mem[sw_wa] <= q.wd;
      end
      if (rx_we) begin
         mem[rx_wa] <= iso_rx_byte;
      end
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready  = q.wready;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_arready = q.arready;
   assign s_axi_rdata   = {24'h000000, q.rdata};
   assign s_axi_rresp   = q.rresp;
   assign s_axi_rvalid  = q.rvalid;
   assign iso_tx_byte   = q.tx_byte;
   assign iso_tx_len    = q.tx_len;
   assign irq_o         = q.irq;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   property p_clear_repulse;
      q.clr_seen && any |=> q.irq [*2];
   endproperty
   a_clear_repulse: assert property (p_clear_repulse)
      else $error("no pulse after clear with pending");

   property p_pulse_cause;
      $rose(q.irq) |-> $past(any);
   endproperty
   a_pulse_cause: assert property (p_pulse_cause)
      else $error("pulse without enabled pending source");

   property p_pulse_short;
      q.irq && q.pcnt == 2'h1 && !trig |=> !q.irq;
   endproperty
   a_pulse_short: assert property (p_pulse_short)
      else $error("pulse too long");

   property p_vec_top;
      pend[0] |=> q.ivec == 7'h00;
   endproperty
   a_vec_top: assert property (p_vec_top)
      else $error("setup data not highest priority");

   property p_vec_ep0in;
      pend[5] && pend[4:0] == 5'h00 |=> q.ivec == 7'h18;
   endproperty
   a_vec_ep0in: assert property (p_vec_ep0in)
      else $error("endpoint 0 IN vector wrong");

   property p_in_set;
      ev_in_ack[0] |=> q.in_irq[0];
   endproperty
   a_in_set: assert property (p_in_set)
      else $error("IN flag not set");

   property p_bus_clear;
      q.bus_irq[3] && clr_bus[3] && !ev_bus[3] |=> !q.bus_irq[3];
   endproperty
   a_bus_clear: assert property (p_bus_clear)
      else $error("bus flag not cleared by one");

   property p_sof_err;
      ev_bus[`UDI_BIT_SOF] |=> q.crc_err == $past(q.crc_pend);
   endproperty
   a_sof_err: assert property (p_sof_err)
      else $error("CRC status not refreshed at frame");

   property p_zero_len;
      ev_bus[`UDI_BIT_SOF] && q.zero_pend |=> q.zero_len;
   endproperty
   a_zero_len: assert property (p_zero_len)
      else $error("zero length status missing");

   property p_rd_adv;
      s_axi_arvalid && q.arready && ar_idx == `UDI_IDX_OUT_DATA &&
      !ev_bus[`UDI_BIT_SOF] |=> q.rd_ptr == $past(q.rd_ptr) + 6'h01;
   endproperty
   a_rd_adv: assert property (p_rd_adv)
      else $error("iso read pointer not advanced");

   c_repulse: cover property (q.clr_seen && any ##1 q.irq);
   c_two_src: cover property (pend[0] && pend[5]);
   c_iso_rd: cover property (q.rvalid && q.crc_err);
endmodule : udi_ctrl
`default_nettype wire

// file: udi_fw_model.sv
/*
 Firmware-side interrupt latch of the controller's request line.
 Assumes irq_i pulses high on ref_clk; clr_main is a one-cycle ack.
*/
`timescale 1ns/10ps
`default_nettype none
module udi_fw_model (
   input  wire logic ref_clk,
   input  wire logic rstn,
   input  wire logic irq_i,
   input  wire logic clr_main,
   output logic      main_flag,
   output int        pulses
);
   logic irq_q;
   // Edge-triggered capture of each request pulse
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         irq_q     <= 1'b0;
         main_flag <= 1'b0;
         pulses    <= 0;
      end else begin
         irq_q <= irq_i;
         if (irq_i && !irq_q) begin
            main_flag <= 1'b1;
            pulses    <= pulses + 1;
         end else if (clr_main) begin
            main_flag <= 1'b0;
         end
      end
   end
endmodule : udi_fw_model
`default_nettype wire

// file: tb_usb_device_irq_and_iso_status.sv
/*
 Self-checking bench of udi_ctrl: AXI4-Lite master, event driver,
 firmware interrupt model.
 Assumes udi_map.svh and udi_fw_model are compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none
`include "udi_map.svh"
`define CHK(nm, ex, gt) begin checked++; if ((ex) !== (gt)) begin \
 miscompares++; $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
 end end
module tb_usb_device_irq_and_iso_status;
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = '0;
   logic [3:0]  wsb = 4'h1;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, irq_o, main_flag;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [16:0] evv = '0, p;
   logic        iso_rx_valid = 0, iso_rx_end = 0, iso_rx_crc_err = 0;
   logic        iso_tx_rd = 0, clr_main = 0;
   logic [7:0]  iso_rx_byte = '0, iso_tx_byte;
   logic [6:0]  iso_tx_len, v;
   logic [7:0]  b [4], bw [12];
   int          seed = 32'h80bb36d1;
   int          checked = 0, miscompares = 0, pulses, exp_p, k, m;

   udi_ctrl uut (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .ev_in_ack(evv[5:0]), .ev_out_ok(evv[11:6]), .ev_bus(evv[16:12]),
      .iso_rx_valid, .iso_rx_byte, .iso_rx_end, .iso_rx_crc_err,
      .iso_tx_rd, .iso_tx_byte, .iso_tx_len, .irq_o);
   udi_fw_model fw (.ref_clk, .rstn, .irq_i(irq_o), .clr_main,
      .main_flag, .pulses);

   always #20 ref_clk = ~ref_clk;

   task automatic give_verdict();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      @(posedge ref_clk);
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= {24'h0, d};
      s_axi_wstrb   <= wsb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [15:0] idx);
      @(posedge ref_clk);
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd  = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rdr

   task automatic rc(input logic [15:0] idx, input logic [31:0] ex);
      rdr(idx);
      `CHK($sformatf("reg %h", idx), ex, rd)
   endtask : rc

   task automatic ev(input logic [16:0] e);
      @(posedge ref_clk);
      evv <= e;
      @(posedge ref_clk);
      evv <= '0;
      repeat (6) @(posedge ref_clk);
   endtask : ev

   task automatic rx(input logic vl, input logic [7:0] d, input logic e,
                     input logic c);
      @(posedge ref_clk);
      iso_rx_valid   <= vl;
      iso_rx_byte    <= d;
      iso_rx_end     <= e;
      iso_rx_crc_err <= c;
   endtask : rx

   // Code of the lowest-coded pending source
   function automatic logic [6:0] exp_vec(input logic [16:0] q);
      exp_vec = 7'h7f;
      for (int j = 5; j >= 0; j--) begin
         if (q[6+j]) exp_vec = 7'h1c + 7'(8 * j);
         if (q[j]) exp_vec = 7'h18 + 7'(8 * j);
      end
      for (int j = 4; j >= 0; j--)
         if (q[12+j]) exp_vec = 7'(4 * j);
   endfunction : exp_vec

   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      give_verdict();
   end

   initial begin
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      for (int j = 0; j < 6; j++) rc(`UDI_IDX_IN_IRQ + 16'(j), 32'h0);
      wr(16'h0000, 8'h55);
      `CHK("bresp", `UDI_RESP_DECERR, rsp)
      rdr(16'h0000);
      `CHK("rresp", `UDI_RESP_DECERR, rsp)
      for (int n = 0; n < 12; n++) begin
         bw[n] = 8'($random(seed));
         wr(16'hc700 - 16'(n * 64), bw[n]);
      end
      for (int n = 0; n < 12; n += 2) begin
         rc(16'hc700 - 16'(n * 64), {24'h0, bw[n]});
         rc(16'hc6c0 - 16'(n * 64), {24'h0, bw[n+1]});
      end
      for (int j = 0; j < 3; j++) begin
         wr(`UDI_IDX_IN_IEN + 16'(j), (j == 2) ? 8'h1f : 8'h3f);
         rc(`UDI_IDX_IN_IEN + 16'(j), (j == 2) ? 32'h1f : 32'h3f);
      end
      for (int r = 0; r < 3; r++) begin
         p = (r == 0) ? 17'h1ffff : 17'($random(seed)) | 17'h1;
         exp_p = pulses + 1;
         ev(p);
         `CHK("pulses", exp_p, pulses)
         rc(`UDI_IDX_IN_IRQ, {26'h0, p[5:0]});
         rc(`UDI_IDX_OUT_IRQ, {26'h0, p[11:6]});
         while (p != 0) begin
            `CHK("main", 1'b1, main_flag)
            v = exp_vec(p);
            rc(`UDI_IDX_IVEC, {25'h0, v});
            for (int j = 0; j < 17; j++)
               if (exp_vec(17'h1 << j) == v) k = j;
            clr_main <= 1'b1;
            @(posedge ref_clk);
            clr_main <= 1'b0;
            if (k >= 12) wr(`UDI_IDX_BUS_IRQ, 8'(1 << (k - 12)));
            else if (k >= 6) wr(`UDI_IDX_OUT_IRQ, 8'(1 << (k - 6)));
            else wr(`UDI_IDX_IN_IRQ, 8'(1 << k));
            p[k] = 1'b0;
            repeat (6) @(posedge ref_clk);
            if (p != 0) exp_p++;
            `CHK("pulses", exp_p, pulses)
            rc(`UDI_IDX_BUS_IRQ, {27'h0, p[16:12]});
         end
      end
      wr(`UDI_IDX_IN_IEN, 8'h3e);
      wsb = 4'h0;
      wr(`UDI_IDX_IN_IEN, 8'h00);
      wsb = 4'h1;
      rc(`UDI_IDX_IN_IEN, 32'h3e);
      wr(`UDI_IDX_BUS_IEN, 8'h00);
      exp_p = pulses;
      ev(17'h18001);
      `CHK("pulses", exp_p, pulses)
      wr(`UDI_IDX_BUS_IRQ, 8'h00);
      rc(`UDI_IDX_BUS_IRQ, 32'h18);
      rc(`UDI_IDX_IN_IRQ, 32'h01);
      wr(`UDI_IDX_BUS_IRQ, 8'hff);
      rc(`UDI_IDX_BUS_IRQ, 32'h0);
      m = 1 + ($random(seed) & 3);
      for (int j = 0; j < m; j++) begin
         b[j] = 8'($random(seed));
         rx(1'b1, b[j], 1'b0, 1'b0);
      end
      rx(1'b0, 8'h0, 1'b1, 1'b1);
      rx(1'b0, 8'h0, 1'b0, 1'b0);
      ev(17'h02000);
      rc(`UDI_IDX_ISO_ERR, 32'h1);
      rc(`UDI_IDX_CNT_HIGH, 32'h0);
      rc(`UDI_IDX_CNT_LOW, 32'(m));
      for (int j = 0; j < m; j++)
         rc(`UDI_IDX_OUT_DATA, {24'h0, b[j]});
      rx(1'b0, 8'h0, 1'b1, 1'b0);
      rx(1'b0, 8'h0, 1'b0, 1'b0);
      ev(17'h02000);
      rc(`UDI_IDX_ZERO_LEN, 32'h1);
      rc(`UDI_IDX_ISO_ERR, 32'h0);
      rc(`UDI_IDX_CNT_LOW, 32'h0);
      for (int j = 0; j < m; j++) begin
         b[j] = 8'($random(seed));
         wr(`UDI_IDX_IN_DATA, b[j]);
      end
      ev(17'h02000);
      `CHK("tx_len", 7'(m), iso_tx_len)
      for (int j = 0; j < m; j++) begin
         @(posedge ref_clk);
         iso_tx_rd <= 1'b1;
         @(posedge ref_clk);
         iso_tx_rd <= 1'b0;
         #1;
         `CHK("tx_byte", b[j], iso_tx_byte)
      end
      give_verdict();
   end
endmodule : tb_usb_device_irq_and_iso_status
`default_nettype wire
